//--- hdl/three_timer_counter_unit.v
`timescale 1ns/1ps
`include "timer_unit_regs.vh"
// Behaviour
// - Timer ticks per machine cycle, 12/6 clocks
// - Counter samples pin, counts high-to-low
// - Gate bit adds interrupt-pin high condition
// - Function bit selects cycles or pin
// - Modes: 13-bit, 16-bit, 8-bit reload
// - Mode 3 splits timer0, stops timer1
// - Overflow flags: hardware set, ack/software clear
// - Run bits only software controlled
// - Interrupt flag set on edge, ack clears
// - Type bit selects falling edge or level
// - Clock-out enable toggles pin on overflow when timer2 counts cycles
// - Down enable permits timer2 down count
// - Timer2 flag not set when baud clocked
// - Trigger falling edge sets external flag
// - External flag no interrupt in up/down
// - Clock selects route timer2 or timer1
// - Trigger capture/reload ignored unless enabled, not baud
// - Timer2 run bit starts and stops
// - Timer2 function bit selects cycles or pin
// - Capture on edge, or reload on overflow/edge
// - Baud clocking forces reload on overflow
// - 8-bit reload: low from high byte
// - Up/down direction follows trigger pin
// - Down overflow loads ones, up loads capture
// - Clock-out: square wave, no overflow interrupt
module three_timer_counter_unit (
	input wire REF_CLK_IN, // System clock
	input wire NRST_IN, // Async reset, active low
	input wire PSEL_IN, // APB select
	input wire PENABLE_IN, // APB enable
	input wire PWRITE_IN, // APB direction
	input wire [11:0] PADDR_IN, // APB byte address
	input wire [31:0] PWDATA_IN, // APB write data
	output wire [31:0] PRDATA_OUT, // APB read data
	output wire PREADY_OUT, // APB ready
	output wire PSLVERR_OUT, // APB error on unmapped address
	input wire COUNT_PIN_ZERO_IN, // Timer0 count pin
	input wire COUNT_PIN_ONE_IN, // Timer1 count pin
	input wire COUNT_PIN_TWO_IN, // Timer2 count pin
	input wire EXT_IRQ_PIN_ZERO_N_IN, // Ext interrupt 0, active low
	input wire EXT_IRQ_PIN_ONE_N_IN, // Ext interrupt 1, active low
	input wire CAPTURE_TRIGGER_PIN_IN, // Timer2 trigger pin
	input wire ACK_T0_IN, // Vector taken: timer0
	input wire ACK_T1_IN, // Vector taken: timer1
	input wire ACK_EXT0_IN, // Vector taken: ext 0
	input wire ACK_EXT1_IN, // Vector taken: ext 1
	output reg CLOCK_OUTPUT_PIN_OUT, // Clock output pin level
	output wire CLOCK_OUTPUT_PIN_OE_OUT, // Clock output enable
	output reg IRQ_T0_OUT, // Timer0 request
	output reg IRQ_T1_OUT, // Timer1 request
	output reg IRQ_EXT0_OUT, // Ext 0 request
	output reg IRQ_EXT1_OUT, // Ext 1 request
	output reg IRQ_T2_OUT, // Timer2 request
	output reg TX_BAUD_TICK_OUT, // Serial transmit clock pulse
	output reg RX_BAUD_TICK_OUT // Serial receive clock pulse
);
	// ****************************************
	// Registers and synchronisers
	// ****************************************
	reg [7:0] mode_sel_ff, run_flags_ff, t2_out_dir_ff, t2_run_flags_ff, misc_ff;
	reg [7:0] tl0_ff, th0_ff, tl1_ff, th1_ff;
	reg [15:0] t2_ff, cap_ff;
	reg [5:0] sync1_ff, sync2_ff, prev_ff;
	reg [3:0] phase_ff;
	reg [31:0] rdata_ff;
	reg slverr_ff;
	wire wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
	// Read data is loaded in the setup cycle so that it stands at the access edge
	wire rd = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
	// Pin bundle into two-flop synchroniser
	wire [5:0] pins = {CAPTURE_TRIGGER_PIN_IN, ~EXT_IRQ_PIN_ONE_N_IN, ~EXT_IRQ_PIN_ZERO_N_IN,
		COUNT_PIN_TWO_IN, COUNT_PIN_ONE_IN, COUNT_PIN_ZERO_IN};
	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
		end else begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
		end
	end
	// Machine cycle strobe; misc bit 0 high selects 12 clocks
	wire [3:0] cyc_last = misc_ff[0] ? `CYC_SLOW : `CYC_FAST;
	wire mc = (phase_ff >= cyc_last);
	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN)
			phase_ff <= 4'h0;
		else
			phase_ff <= mc ? 4'h0 : phase_ff + 4'h1;
	end
	// Sample history once per machine cycle; falling edge = old high, new low
	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN)
			prev_ff <= 6'h00;
		else if (mc)
			prev_ff <= sync2_ff;
	end
	wire [5:0] fall = prev_ff & ~sync2_ff & {6{mc}};
	// Irq pins are held inverted here, so a falling pin shows as a rise
	wire [1:0] ext_edge = sync2_ff[4:3] & ~prev_ff[4:3] & {2{mc}};
	wire ext_irq_pin_zero_hi = ~sync2_ff[3];
	wire ext_irq_pin_one_hi = ~sync2_ff[4];
	// ****************************************
	// Timer 0 and 1 enables
	// ****************************************
	wire [1:0] m0 = mode_sel_ff[1:0];
	wire [1:0] m1 = mode_sel_ff[5:4];
	wire run0 = run_flags_ff[`RF_RUN_ZERO] & (~mode_sel_ff[3] | ext_irq_pin_zero_hi);
	wire run1 = run_flags_ff[`RF_RUN_ONE] & (~mode_sel_ff[7] | ext_irq_pin_one_hi);
	wire inc0 = run0 & (mode_sel_ff[2] ? fall[0] : mc);
	wire inc1 = run1 & (m1 != 2'b11) & (mode_sel_ff[6] ? fall[1] : mc);
	wire inc0h = run_flags_ff[`RF_RUN_ONE] & mc;
	reg ovf0, ovf1;
	reg [7:0] n_tl0, n_th0, n_tl1, n_th1;
	// Per-timer increment for modes 0-3, including the mode 3 split of timer0
	always @* begin
		n_tl0 = tl0_ff;
		n_th0 = th0_ff;
		n_tl1 = tl1_ff;
		n_th1 = th1_ff;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		if (inc0) begin
			case (m0)
				2'b00: begin
					n_tl0 = {3'h0, tl0_ff[4:0] + 5'h01};
					if (tl0_ff[4:0] == 5'h1F) begin
						n_th0 = th0_ff + 8'h01;
						ovf0 = (th0_ff == 8'hFF);
					end
				end
				2'b01: begin
					{n_th0, n_tl0} = {th0_ff, tl0_ff} + 16'h0001;
					ovf0 = ({th0_ff, tl0_ff} == 16'hFFFF);
				end
				2'b10: begin
					n_tl0 = (tl0_ff == 8'hFF) ? th0_ff : tl0_ff + 8'h01;
					ovf0 = (tl0_ff == 8'hFF);
				end
				default: begin
					n_tl0 = tl0_ff + 8'h01;
					ovf0 = (tl0_ff == 8'hFF);
				end
			endcase
		end
		if (m0 == 2'b11 && inc0h) begin
			n_th0 = th0_ff + 8'h01;
			ovf1 = (th0_ff == 8'hFF);
		end
		if (inc1) begin
			case (m1)
				2'b00: begin
					n_tl1 = {3'h0, tl1_ff[4:0] + 5'h01};
					if (tl1_ff[4:0] == 5'h1F) begin
						n_th1 = th1_ff + 8'h01;
						ovf1 = (th1_ff == 8'hFF);
					end
				end
				2'b01: begin
					{n_th1, n_tl1} = {th1_ff, tl1_ff} + 16'h0001;
					ovf1 = ({th1_ff, tl1_ff} == 16'hFFFF);
				end
				default: begin
					n_tl1 = (tl1_ff == 8'hFF) ? th1_ff : tl1_ff + 8'h01;
					ovf1 = (tl1_ff == 8'hFF);
				end
			endcase
		end
	end
	// Timer1 overflow gated by timer1 increment; in timer1 mode 0 a coincident split-mode overflow can also pass
	wire t1_baud = inc1 & ovf1;
	// ****************************************
	// Timer 2
	// ****************************************
	wire baud = t2_run_flags_ff[`T2_RXCLK] | t2_run_flags_ff[`T2_TXCLK];
	wire updown = t2_out_dir_ff[`T2M_DOWN] & ~t2_run_flags_ff[`T2_CAPREL] & ~baud;
	wire trig_hi = sync2_ff[5];
	wire inc2 = t2_run_flags_ff[`T2_RUN] & (t2_run_flags_ff[`T2_FUNC] ? fall[2] : mc);
	wire trig_ev = fall[5] & t2_run_flags_ff[`T2_TRIG_EN] & ~updown;
	wire up = ~updown | trig_hi;
	wire ovf2 = inc2 & (up ? (t2_ff == 16'hFFFF) : (t2_ff == cap_ff));
	wire clkout = t2_out_dir_ff[`T2M_CLKOUT] & ~t2_run_flags_ff[`T2_FUNC];
	reg [15:0] n_t2;
	// Timer2 counting, reload and capture selection
	always @* begin
		n_t2 = t2_ff;
		if (inc2)
			n_t2 = up ? t2_ff + 16'h0001 : t2_ff - 16'h0001;
		if (ovf2) begin
			if (updown)
				n_t2 = up ? cap_ff : 16'hFFFF;
			else if (baud || !t2_run_flags_ff[`T2_CAPREL])
				n_t2 = cap_ff;
		end
		if (trig_ev && !baud && !t2_run_flags_ff[`T2_CAPREL])
			n_t2 = cap_ff;
	end
	wire capture = trig_ev & ~baud & t2_run_flags_ff[`T2_CAPREL];
	// ****************************************
	// APB slave
	// ****************************************
	wire sel_known = (PADDR_IN[11:2] <= 10'h008) && (PADDR_IN[1:0] == 2'b00);
	assign PREADY_OUT = 1'b1;
	assign PRDATA_OUT = rdata_ff;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~sel_known;
	assign CLOCK_OUTPUT_PIN_OE_OUT = clkout;
	reg [31:0] rmux;
	// Read mux of live state
	always @* begin
		case (PADDR_IN)
			`ADDR_MODE_SEL: rmux = {24'h0, mode_sel_ff};
			`ADDR_RUN_FLAGS: rmux = {24'h0, run_flags_ff};
			`ADDR_T2_OUT_DIR: rmux = {30'h0, t2_out_dir_ff[1:0]};
			`ADDR_T2_RUN_FLAGS: rmux = {24'h0, t2_run_flags_ff};
			`ADDR_T0_COUNT: rmux = {16'h0, th0_ff, tl0_ff};
			`ADDR_T1_COUNT: rmux = {16'h0, th1_ff, tl1_ff};
			`ADDR_T2_COUNT: rmux = {16'h0, t2_ff};
			`ADDR_T2_CAPTURE: rmux = {16'h0, cap_ff};
			`ADDR_MISC_CTRL: rmux = {31'h0, misc_ff[0]};
			default: rmux = 32'h0;
		endcase
	end
	wire w_rf = wr & (PADDR_IN == `ADDR_RUN_FLAGS);
	wire w_t2 = wr & (PADDR_IN == `ADDR_T2_RUN_FLAGS);
	// Flag next values: hardware set wins over clear
	wire ext0_set = run_flags_ff[`RF_EXT_TYPE_ZERO] ? ext_edge[0] : sync2_ff[3];
	wire ext1_set = run_flags_ff[`RF_EXT_TYPE_ONE] ? ext_edge[1] : sync2_ff[4];
	reg [7:0] nxt_rf, nxt_t2f;
	always @* begin
		nxt_rf = w_rf ? PWDATA_IN[7:0] : run_flags_ff;
		if (ACK_T0_IN)
			nxt_rf[`RF_OVF_ZERO] = 1'b0;
		if (ACK_T1_IN)
			nxt_rf[`RF_OVF_ONE] = 1'b0;
		if (ACK_EXT0_IN)
			nxt_rf[`RF_EXT_FLAG_ZERO] = 1'b0;
		if (ACK_EXT1_IN)
			nxt_rf[`RF_EXT_FLAG_ONE] = 1'b0;
		if (ovf0)
			nxt_rf[`RF_OVF_ZERO] = 1'b1;
		if (ovf1)
			nxt_rf[`RF_OVF_ONE] = 1'b1;
		if (ext0_set)
			nxt_rf[`RF_EXT_FLAG_ZERO] = 1'b1;
		if (ext1_set)
			nxt_rf[`RF_EXT_FLAG_ONE] = 1'b1;
		nxt_t2f = w_t2 ? PWDATA_IN[7:0] : t2_run_flags_ff;
		if (ovf2 && !baud && !clkout)
			nxt_t2f[`T2_OVF] = 1'b1;
		if (fall[5] && t2_run_flags_ff[`T2_TRIG_EN] && !updown)
			nxt_t2f[`T2_EXT] = 1'b1;
		if (ovf2 && updown)
			nxt_t2f[`T2_EXT] = ~t2_run_flags_ff[`T2_EXT];
	end
	// Register update
	always @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			mode_sel_ff <= `RST_BYTE;
			run_flags_ff <= `RST_BYTE;
			t2_out_dir_ff <= `RST_BYTE;
			t2_run_flags_ff <= `RST_BYTE;
			misc_ff <= `RST_MISC;
			tl0_ff <= `RST_BYTE;
			th0_ff <= `RST_BYTE;
			tl1_ff <= `RST_BYTE;
			th1_ff <= `RST_BYTE;
			t2_ff <= 16'h0000;
			cap_ff <= 16'h0000;
			rdata_ff <= 32'h0;
			CLOCK_OUTPUT_PIN_OUT <= 1'b0;
			IRQ_T0_OUT <= 1'b0;
			IRQ_T1_OUT <= 1'b0;
			IRQ_EXT0_OUT <= 1'b0;
			IRQ_EXT1_OUT <= 1'b0;
			IRQ_T2_OUT <= 1'b0;
			TX_BAUD_TICK_OUT <= 1'b0;
			RX_BAUD_TICK_OUT <= 1'b0;
		end else begin
			run_flags_ff <= nxt_rf;
			t2_run_flags_ff <= nxt_t2f;
			if (wr && PADDR_IN == `ADDR_MODE_SEL)
				mode_sel_ff <= PWDATA_IN[7:0];
			if (wr && PADDR_IN == `ADDR_T2_OUT_DIR)
				t2_out_dir_ff <= {6'h00, PWDATA_IN[1:0]};
			if (wr && PADDR_IN == `ADDR_MISC_CTRL)
				misc_ff <= {7'h00, PWDATA_IN[0]};
			if (wr && PADDR_IN == `ADDR_T0_COUNT) begin
				tl0_ff <= PWDATA_IN[7:0];
				th0_ff <= PWDATA_IN[15:8];
			end else begin
				tl0_ff <= n_tl0;
				th0_ff <= n_th0;
			end
			if (wr && PADDR_IN == `ADDR_T1_COUNT) begin
				tl1_ff <= PWDATA_IN[7:0];
				th1_ff <= PWDATA_IN[15:8];
			end else begin
				tl1_ff <= n_tl1;
				th1_ff <= n_th1;
			end
			if (wr && PADDR_IN == `ADDR_T2_COUNT)
				t2_ff <= PWDATA_IN[15:0];
			else
				t2_ff <= n_t2;
			if (wr && PADDR_IN == `ADDR_T2_CAPTURE)
				cap_ff <= PWDATA_IN[15:0];
			else if (capture)
				cap_ff <= t2_ff;
			if (rd)
				rdata_ff <= rmux;
			if (ovf2 && clkout)
				CLOCK_OUTPUT_PIN_OUT <= ~CLOCK_OUTPUT_PIN_OUT;
			IRQ_T0_OUT <= run_flags_ff[`RF_OVF_ZERO];
			IRQ_T1_OUT <= run_flags_ff[`RF_OVF_ONE];
			IRQ_EXT0_OUT <= run_flags_ff[`RF_EXT_FLAG_ZERO];
			IRQ_EXT1_OUT <= run_flags_ff[`RF_EXT_FLAG_ONE];
			IRQ_T2_OUT <= t2_run_flags_ff[`T2_OVF] | (t2_run_flags_ff[`T2_EXT] & ~updown);
			TX_BAUD_TICK_OUT <= t2_run_flags_ff[`T2_TXCLK] ? ovf2 : t1_baud;
			RX_BAUD_TICK_OUT <= t2_run_flags_ff[`T2_RXCLK] ? ovf2 : t1_baud;
		end
	end
endmodule // three_timer_counter_unit

//--- hdl/timer_unit_regs.vh
`ifndef TIMER_UNIT_REGS_VH
`define TIMER_UNIT_REGS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_MODE_SEL 12'h000
`define ADDR_RUN_FLAGS 12'h004
`define ADDR_T2_OUT_DIR 12'h008
`define ADDR_T2_RUN_FLAGS 12'h00C
`define ADDR_T0_COUNT 12'h010
`define ADDR_T1_COUNT 12'h014
`define ADDR_T2_COUNT 12'h018
`define ADDR_T2_CAPTURE 12'h01C
`define ADDR_MISC_CTRL 12'h020
// ****************************************
// Field positions
// ****************************************
`define RF_OVF_ONE 7
`define RF_RUN_ONE 6
`define RF_OVF_ZERO 5
`define RF_RUN_ZERO 4
`define RF_EXT_FLAG_ONE 3
`define RF_EXT_TYPE_ONE 2
`define RF_EXT_FLAG_ZERO 1
`define RF_EXT_TYPE_ZERO 0
`define T2_OVF 7
`define T2_EXT 6
`define T2_RXCLK 5
`define T2_TXCLK 4
`define T2_TRIG_EN 3
`define T2_RUN 2
`define T2_FUNC 1
`define T2_CAPREL 0
`define T2M_CLKOUT 1
`define T2M_DOWN 0
// ****************************************
// Reset values and timing
// ****************************************
`define RST_BYTE 8'h00
`define RST_MISC 8'h01
`define CYC_SLOW 4'hB
`define CYC_FAST 4'h5
`endif

//--- verification/timer_unit_properties.sv
`timescale 1ns/1ps
module timer_unit_properties (
	input wire REF_CLK_IN,
	input wire NRST_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [31:0] PRDATA_OUT,
	input wire PREADY_OUT,
	input wire PSLVERR_OUT,
	input wire EXT_IRQ_PIN_ZERO_N_IN,
	input wire EXT_IRQ_PIN_ONE_N_IN,
	input wire ACK_EXT0_IN,
	input wire ACK_EXT1_IN,
	input wire CLOCK_OUTPUT_PIN_OUT,
	input wire IRQ_EXT0_OUT,
	input wire IRQ_EXT1_OUT,
	input wire TX_BAUD_TICK_OUT,
	input wire RX_BAUD_TICK_OUT
);
	// ****
	// Port checks
	// ****
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	// Pin pulled low long enough, with no acknowledge meanwhile
	sequence s_low0;
		$fell(EXT_IRQ_PIN_ZERO_N_IN) ##1 (!EXT_IRQ_PIN_ZERO_N_IN && !ACK_EXT0_IN)[*5];
	endsequence
	sequence s_low1;
		$fell(EXT_IRQ_PIN_ONE_N_IN) ##1 (!EXT_IRQ_PIN_ONE_N_IN && !ACK_EXT1_IN)[*5];
	endsequence
	a_ready_high: assert property (PREADY_OUT) else $error("ready low");
	a_err_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN) else $error("stray error");
	a_rdata_hold: assert property (!(PSEL_IN && !PENABLE_IN && !PWRITE_IN) |=> $stable(PRDATA_OUT))
		else $error("read data moved");
	a_tx_pulse: assert property (TX_BAUD_TICK_OUT |=> !TX_BAUD_TICK_OUT) else $error("tx tick");
	a_rx_pulse: assert property (RX_BAUD_TICK_OUT |=> !RX_BAUD_TICK_OUT) else $error("rx tick");
	a_pin_spacing: assert property ($changed(CLOCK_OUTPUT_PIN_OUT) |=>
		$stable(CLOCK_OUTPUT_PIN_OUT)[*5]) else $error("clock pin too fast");
	a_ext_zero_sets: assert property (s_low0 |-> ##[0:4] IRQ_EXT0_OUT) else $error("ext0 lost");
	a_ext_one_sets: assert property (s_low1 |-> ##[0:4] IRQ_EXT1_OUT) else $error("ext1 lost");
endmodule // timer_unit_properties

//--- verification/pin_source.sv
`timescale 1ns/1ps
module pin_source (
	input wire clk_in, // Bench clock
	output reg [5:0] pins_out // Count 0..2, irq 0..1 (low active), trigger
);
	// Every line idles high
	initial pins_out = 6'h3F;
	// Each level held a machine cycle plus the sync delay
	task automatic falls(input int idx, input int cnt);
		repeat (cnt) begin
			repeat (14) @(posedge clk_in);
			pins_out[idx] <= 1'b0;
			repeat (14) @(posedge clk_in);
			pins_out[idx] <= 1'b1;
		end
	endtask
	// Set one line to a level
	task automatic set(input int idx, input logic v);
		@(posedge clk_in);
		pins_out[idx] <= v;
	endtask
endmodule // pin_source

//--- verification/tb.sv
`timescale 1ns/1ps
`include "timer_unit_regs.vh"
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] q;
	logic [3:0] acks = 4'h0;
	logic slv, p;
	wire [31:0] prdata;
	wire [5:0] pins;
	wire [4:0] irq;
	wire pready, pslverr, pin_out, oe, tx, rx;
	int err_count = 0;
	int tests_run = 0;
	int n, k;
	logic [11:0] ra [5];
	logic [31:0] rw [5];
	logic [31:0] re [5];
	always #20 clk = ~clk;
	pin_source u_pin_source (.clk_in(clk), .pins_out(pins));
	three_timer_counter_unit u_three_timer_counter_unit (.REF_CLK_IN(clk), .NRST_IN(nrst),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.COUNT_PIN_ZERO_IN(pins[0]), .COUNT_PIN_ONE_IN(pins[1]), .COUNT_PIN_TWO_IN(pins[2]),
		.EXT_IRQ_PIN_ZERO_N_IN(pins[3]), .EXT_IRQ_PIN_ONE_N_IN(pins[4]),
		.CAPTURE_TRIGGER_PIN_IN(pins[5]), .ACK_T0_IN(acks[0]), .ACK_T1_IN(acks[1]),
		.ACK_EXT0_IN(acks[2]), .ACK_EXT1_IN(acks[3]), .CLOCK_OUTPUT_PIN_OUT(pin_out),
		.CLOCK_OUTPUT_PIN_OE_OUT(oe), .IRQ_T0_OUT(irq[0]), .IRQ_T1_OUT(irq[1]),
		.IRQ_EXT0_OUT(irq[2]), .IRQ_EXT1_OUT(irq[3]), .IRQ_T2_OUT(irq[4]),
		.TX_BAUD_TICK_OUT(tx), .RX_BAUD_TICK_OUT(rx));
	// ****
	// Bus and check tasks
	// ****
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		slv = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic wait_irq(input int i);
		n = 0;
		while (irq[i] !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic ack(input int i);
		@(posedge clk);
		acks[i] <= 1'b1;
		@(posedge clk);
		acks[i] <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#2000000;
		err_count++;
		print_verdict();
	end
	// Main sequence
	initial begin
		ra = '{`ADDR_MODE_SEL, `ADDR_T2_CAPTURE, `ADDR_T2_OUT_DIR, `ADDR_T0_COUNT, 12'h040};
		rw = '{32'hA5, 32'hBEEF, 32'hFF, 32'h1234, 32'hFFFF};
		re = '{32'hA5, 32'hBEEF, 32'h3, 32'h1234, 32'h0};
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(`ADDR_MODE_SEL, 32'h0);
		rd(`ADDR_RUN_FLAGS, 32'h0);
		rd(`ADDR_T2_RUN_FLAGS, 32'h0);
		rd(`ADDR_MISC_CTRL, 32'h1);
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			wr(ra[i], rw[i]);
			rd(ra[i], re[i]);
			chk({31'h0, slv}, {31'h0, i == 4});
		end
		$display("register table done");
		// Overflow time at both machine cycle lengths, then acknowledge
		for (int s = 0; s < 2; s++) begin
			wr(`ADDR_MISC_CTRL, 32'(1 - s));
			wr(`ADDR_MODE_SEL, 32'h01);
			wr(`ADDR_T0_COUNT, 32'hFFF0);
			wr(`ADDR_RUN_FLAGS, 32'h10);
			wait_irq(0);
			k = s ? 6 : 12;
			chk({31'h0, n >= 15 * k && n <= 17 * k + 4}, 32'h1);
			rd(`ADDR_RUN_FLAGS, 32'h30);
			ack(0);
			rd(`ADDR_RUN_FLAGS, 32'h10);
			chk({31'h0, irq[0]}, 32'h0);
			wr(`ADDR_RUN_FLAGS, 32'h0);
		end
		$display("timer mode test done");
		wr(`ADDR_MODE_SEL, 32'h02);
		wr(`ADDR_T0_COUNT, 32'h80FE);
		wr(`ADDR_RUN_FLAGS, 32'h10);
		wait_irq(0);
		wr(`ADDR_RUN_FLAGS, 32'h0);
		xfer(1'b0, `ADDR_T0_COUNT, 32'h0);
		chk({24'h0, q[15:8]}, 32'h80);
		chk({31'h0, q[7:0] <= 8'h81}, 32'h1);
		$display("reload test done");
		wr(`ADDR_MISC_CTRL, 32'h1);
		wr(`ADDR_MODE_SEL, 32'h50);
		wr(`ADDR_T1_COUNT, 32'h0);
		wr(`ADDR_RUN_FLAGS, 32'h40);
		u_pin_source.falls(1, 5);
		repeat (30) @(posedge clk);
		rd(`ADDR_T1_COUNT, 32'h5);
		$display("counter test done");
		wr(`ADDR_MODE_SEL, 32'h09);
		wr(`ADDR_T0_COUNT, 32'h0);
		u_pin_source.set(3, 1'b0);
		wr(`ADDR_RUN_FLAGS, 32'h10);
		repeat (100) @(posedge clk);
		rd(`ADDR_T0_COUNT, 32'h0);
		chk({31'h0, irq[2]}, 32'h1);
		u_pin_source.set(3, 1'b1);
		repeat (60) @(posedge clk);
		wr(`ADDR_RUN_FLAGS, 32'h0);
		xfer(1'b0, `ADDR_T0_COUNT, 32'h0);
		chk({31'h0, q != 32'h0}, 32'h1);
		ack(2);
		rd(`ADDR_RUN_FLAGS, 32'h0);
		wr(`ADDR_RUN_FLAGS, 32'h01);
		u_pin_source.falls(3, 1);
		rd(`ADDR_RUN_FLAGS, 32'h03);
		ack(2);
		rd(`ADDR_RUN_FLAGS, 32'h01);
		wr(`ADDR_RUN_FLAGS, 32'h0);
		$display("gate test done");
		wr(`ADDR_MODE_SEL, 32'h20);
		wr(`ADDR_T1_COUNT, 32'hFFFF);
		wr(`ADDR_RUN_FLAGS, 32'h40);
		k = 0;
		repeat (120) begin
			@(posedge clk);
			if (tx === 1'b1 && rx === 1'b1) k++;
		end
		chk({31'h0, k >= 9 && k <= 11}, 32'h1);
		wr(`ADDR_RUN_FLAGS, 32'h0);
		$display("baud test done");
		wr(`ADDR_T2_OUT_DIR, 32'h2);
		wr(`ADDR_T2_CAPTURE, 32'hFFFE);
		wr(`ADDR_T2_COUNT, 32'hFFFE);
		wr(`ADDR_T2_RUN_FLAGS, 32'h04);
		k = 0;
		p = pin_out;
		repeat (240) begin
			@(posedge clk);
			if (pin_out !== p) k++;
			p = pin_out;
		end
		chk({31'h0, k >= 8 && k <= 11}, 32'h1);
		chk({31'h0, oe}, 32'h1);
		rd(`ADDR_T2_RUN_FLAGS, 32'h04);
		wr(`ADDR_T2_RUN_FLAGS, 32'h0);
		wr(`ADDR_T2_OUT_DIR, 32'h0);
		$display("clock out test done");
		wr(`ADDR_T2_COUNT, 32'h0);
		wr(`ADDR_T2_RUN_FLAGS, 32'h0D);
		u_pin_source.falls(5, 1);
		xfer(1'b0, `ADDR_T2_CAPTURE, 32'h0);
		chk({31'h0, q <= 32'h8}, 32'h1);
		rd(`ADDR_T2_RUN_FLAGS, 32'h4D);
		chk({31'h0, irq[4]}, 32'h1);
		wr(`ADDR_T2_RUN_FLAGS, 32'h05);
		u_pin_source.falls(5, 1);
		rd(`ADDR_T2_RUN_FLAGS, 32'h05);
		$display("capture test done");
		print_verdict();
	end
endmodule // tb
bind three_timer_counter_unit timer_unit_properties u_timer_unit_properties (
	.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .EXT_IRQ_PIN_ZERO_N_IN(EXT_IRQ_PIN_ZERO_N_IN),
	.EXT_IRQ_PIN_ONE_N_IN(EXT_IRQ_PIN_ONE_N_IN), .ACK_EXT0_IN(ACK_EXT0_IN),
	.ACK_EXT1_IN(ACK_EXT1_IN), .CLOCK_OUTPUT_PIN_OUT(CLOCK_OUTPUT_PIN_OUT),
	.IRQ_EXT0_OUT(IRQ_EXT0_OUT), .IRQ_EXT1_OUT(IRQ_EXT1_OUT),
	.TX_BAUD_TICK_OUT(TX_BAUD_TICK_OUT), .RX_BAUD_TICK_OUT(RX_BAUD_TICK_OUT));
